/* rtl/bld_top.sv */
module bld_top
    import bld_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic [7:0]  adc_result,
    input  wire logic        light_compare_result,
    input  wire logic        light_overflow,
    input  wire logic        light_underflow,
    input  wire logic        light_irq_event,
    input  wire logic        dropout_guard_active,
    output logic [7:0]       sink_on,
    output logic [3:0]       bank_on,
    output logic [3:0]       first_group_fade_on,
    output logic [19:0]      start_level,
    output logic [3:0]       first_group_pulse_on,
    output logic [19:0]      goal_level,
    output logic [14:0]      regulator_code,
    output logic [1:0]       effect_set_select,
    output logic [2:0]       effect_zone_select,
    output logic [5:0]       set_rate,
    output logic [11:0]      set_timing,
    output logic             light_adc_on,
    output logic             light_auto_on,
    output logic             light_saturate_on,
    output logic             light_irq_n,
    output logic [7:0]       light_rise_level,
    output logic [7:0]       light_fall_level,
    output logic             dropout_guard_on,
    output logic             dropout_guard_rate,
    output logic [2:0]       auto_dim_select,
    output logic             pulse_input_bypass
);
    bld_rf_if rf ();

    bld_regfile u_regfile (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .rf       (rf.slave)
    );

    // ---------------- bus line sampling
    logic           scl_q_r;
    logic           sda_q_r;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= scl_in;
            sda_q_r <= sda_in;
        end
    end

    wire scl_rise  = scl_in & ~scl_q_r;
    wire scl_fall  = ~scl_in & scl_q_r;
    wire start_det = scl_in & scl_q_r & sda_q_r & ~sda_in;
    wire stop_det  = scl_in & scl_q_r & ~sda_q_r & sda_in;

    // ---------------- hardware-owned status
    logic           cmp_r;
    logic           of_r;
    logic           uf_r;
    logic           int_r;
    logic           act_r;
    logic [7:0]     result_r;
    logic [3:0]     bank_r;

    // ---------------- protocol state
    bld_state_e     state_r;
    bld_state_e     state_nxt;
    logic [3:0]     cnt_r;
    logic [3:0]     cnt_nxt;
    logic [7:0]     shift_r;
    logic [7:0]     shift_nxt;
    logic [7:0]     tx_r;
    logic [7:0]     tx_nxt;
    logic [7:0]     ptr_r;
    logic [7:0]     ptr_nxt;
    logic           rw_r;
    logic           rw_nxt;
    logic           oe_r;
    logic           oe_nxt;
    logic           wr_r;
    logic           wr_nxt;
    logic [7:0]     wdat_r;
    logic [7:0]     wdat_nxt;

    wire byte_done = scl_fall && (cnt_r == BLD_BYTE_BITS);
    wire addr_hit  = (shift_r[7:1] == BLD_SLAVE_ADDR);

    // read data: stored bits merged with live status
    wire [7:0] als_byte = rf.rd_data
                        | {cmp_r, int_r, 1'b0, of_r, uf_r, 3'b000};
    wire [7:0] dim_byte = rf.rd_data | {1'b0, act_r, 6'b000000};
    wire [7:0] tx_src   = (ptr_r == BLD_ADR_ALS)    ? als_byte :
                          (ptr_r == BLD_ADR_RESULT) ? result_r :
                          (ptr_r == BLD_ADR_DIM)    ? dim_byte :
                          rf.rd_data;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        shift_nxt = shift_r;
        tx_nxt    = tx_r;
        ptr_nxt   = ptr_r;
        rw_nxt    = rw_r;
        oe_nxt    = oe_r;
        wr_nxt    = 1'b0;
        wdat_nxt  = wdat_r;
        if (stop_det) begin
            state_nxt = BLD_IDLE;
            oe_nxt    = 1'b0;
        end else if (start_det) begin
            // also a repeated start: pointer is kept
            state_nxt = BLD_ADDR;
            cnt_nxt   = 4'h0;
            oe_nxt    = 1'b0;
        end else begin
            case (state_r)
                BLD_IDLE: begin
                    oe_nxt = 1'b0;
                end
                BLD_ADDR, BLD_REG, BLD_DATA: begin
                    if (scl_rise) begin
                        shift_nxt = {shift_r[6:0], sda_in};
                        cnt_nxt   = cnt_r + 4'h1;
                    end
                    if (byte_done) begin
                        cnt_nxt = 4'h0;
                        if (state_r == BLD_ADDR) begin
                            if (addr_hit) begin
                                oe_nxt    = 1'b1;
                                rw_nxt    = shift_r[0];
                                state_nxt = BLD_ACKA;
                            end else begin
                                // other slave addressed: stay off the bus
                                state_nxt = BLD_IDLE;
                            end
                        end else if (state_r == BLD_REG) begin
                            ptr_nxt   = shift_r;
                            oe_nxt    = 1'b1;
                            state_nxt = BLD_ACKR;
                        end else begin
                            wr_nxt    = 1'b1;
                            wdat_nxt  = shift_r;
                            oe_nxt    = 1'b1;
                            state_nxt = BLD_ACKD;
                        end
                    end
                end
                BLD_ACKA: begin
                    if (scl_fall) begin
                        if (rw_r) begin
                            tx_nxt    = {tx_src[6:0], 1'b0};
                            oe_nxt    = ~tx_src[7];
                            cnt_nxt   = 4'h1;
                            state_nxt = BLD_READ;
                        end else begin
                            oe_nxt    = 1'b0;
                            state_nxt = BLD_REG;
                        end
                    end
                end
                BLD_ACKR, BLD_ACKD: begin
                    // no auto increment: later bytes rewrite the same register
                    if (scl_fall) begin
                        oe_nxt    = 1'b0;
                        state_nxt = BLD_DATA;
                    end
                end
                BLD_READ: begin
                    if (byte_done) begin
                        oe_nxt    = 1'b0;
                        cnt_nxt   = 4'h0;
                        state_nxt = BLD_MACK;
                    end else if (scl_fall) begin
                        oe_nxt  = ~tx_r[7];
                        tx_nxt  = {tx_r[6:0], 1'b0};
                        cnt_nxt = cnt_r + 4'h1;
                    end
                end
                BLD_MACK: begin
                    if (scl_rise) begin
                        // nack ends the read; ack resends the same register
                        state_nxt = sda_in ? BLD_IDLE : BLD_ACKA;
                    end
                end
                default: begin
                    state_nxt = BLD_IDLE;
                    oe_nxt    = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= BLD_IDLE;
            cnt_r   <= 4'h0;
            shift_r <= 8'h00;
            tx_r    <= 8'h00;
            ptr_r   <= 8'h00;
            rw_r    <= 1'b0;
            oe_r    <= 1'b0;
            wr_r    <= 1'b0;
            wdat_r  <= 8'h00;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            shift_r <= shift_nxt;
            tx_r    <= tx_nxt;
            ptr_r   <= ptr_nxt;
            rw_r    <= rw_nxt;
            oe_r    <= oe_nxt;
            wr_r    <= wr_nxt;
            wdat_r  <= wdat_nxt;
        end
    end

    // masked store keeps reserved bits zero even if the host ignores them
    assign rf.wr_en   = wr_r;
    assign rf.addr    = ptr_r;
    assign rf.wr_data = wdat_r;

    // ---------------- status and bank bookkeeping
    wire wr_als  = wr_r && (ptr_r == BLD_ADR_ALS);
    wire int_clr = wr_als && wdat_r[BLD_ALS_CLR];
    wire wr_bank = wr_r && (ptr_r == BLD_ADR_BANK);
    wire bank_en  = wdat_r[BLD_BANK_EN] & ~wdat_r[BLD_BANK_DIS];
    wire bank_dis = wdat_r[BLD_BANK_DIS] & ~wdat_r[BLD_BANK_EN];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_r    <= 1'b0;
            of_r     <= 1'b0;
            uf_r     <= 1'b0;
            int_r    <= 1'b0;
            act_r    <= 1'b0;
            result_r <= 8'h00;
        end else begin
            cmp_r    <= light_compare_result;
            of_r     <= light_overflow;
            uf_r     <= light_underflow;
            act_r    <= dropout_guard_active;
            result_r <= adc_result;
            // a new event in the clearing cycle is kept
            int_r    <= light_irq_event | (int_r & ~int_clr);
        end
    end

    // both controls set: selector bits do nothing
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bank_r <= 4'h0;
        end else if (wr_bank && bank_en) begin
            bank_r <= bank_r | wdat_r[3:0];
        end else if (wr_bank && bank_dis) begin
            bank_r <= bank_r & ~wdat_r[3:0];
        end
    end

    // sinks seven/eight only when neither bank control is set
    wire [7:0] r_bank = rf.regs[1];
    wire       alt_use = ~r_bank[BLD_BANK_DIS] & ~r_bank[BLD_BANK_EN];

    // ---------------- registered outputs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_out              <= 1'b0;
            sda_oe               <= 1'b0;
            sink_on              <= 8'h00;
            bank_on              <= 4'h0;
            first_group_fade_on  <= 4'h0;
            start_level          <= 20'h00000;
            first_group_pulse_on <= 4'h0;
            goal_level           <= 20'h00000;
            regulator_code       <= 15'h0000;
            effect_set_select    <= 2'h0;
            effect_zone_select   <= 3'h0;
            set_rate             <= 6'h00;
            set_timing           <= 12'h000;
            light_adc_on         <= 1'b0;
            light_auto_on        <= 1'b0;
            light_saturate_on    <= 1'b0;
            light_irq_n          <= 1'b1;
            light_rise_level     <= 8'h00;
            light_fall_level     <= 8'h00;
            dropout_guard_on     <= 1'b0;
            dropout_guard_rate   <= 1'b0;
            auto_dim_select      <= 3'h0;
            pulse_input_bypass   <= 1'b0;
        end else begin
            // open drain: only ever pulls low
            sda_out              <= 1'b0;
            sda_oe               <= oe_nxt;
            sink_on              <= {alt_use ? r_bank[1:0] : 2'b00,
                                     rf.regs[0][5:0]};
            bank_on              <= bank_r;
            for (int b = 0; b < 4; b++) begin
                first_group_fade_on[b]  <= rf.regs[2+b][BLD_FX_ON];
                start_level[5*b +: 5]   <= rf.regs[2+b][4:0];
                first_group_pulse_on[b] <= rf.regs[6+b][BLD_FX_ON];
                goal_level[5*b +: 5]    <= rf.regs[6+b][4:0];
            end
            regulator_code       <= {rf.regs[13][3:0], rf.regs[12][3:0],
                                     rf.regs[11][2:0], rf.regs[10][3:0]};
            effect_set_select    <= rf.regs[14][4:3];
            effect_zone_select   <= rf.regs[14][2:0];
            set_rate             <= rf.regs[15][5:0];
            set_timing           <= {rf.regs[17][5:0], rf.regs[16][5:0]};
            light_adc_on         <= rf.regs[18][BLD_ALS_EN];
            light_auto_on        <= rf.regs[18][BLD_ALS_AUTO];
            light_saturate_on    <= rf.regs[18][BLD_ALS_SAT];
            light_irq_n          <= ~int_r;
            light_rise_level     <= rf.regs[20];
            light_fall_level     <= rf.regs[21];
            dropout_guard_on     <= rf.regs[22][BLD_DIM_ON];
            dropout_guard_rate   <= rf.regs[22][BLD_DIM_RATE];
            auto_dim_select      <= rf.regs[22][3:1];
            pulse_input_bypass   <= rf.regs[22][BLD_DIM_BYP];
        end
    end
endmodule

/* rtl/bld_pkg.sv */
package bld_pkg;
    localparam int          BLD_NUM_REGS   = 23;
    localparam logic [6:0]  BLD_SLAVE_ADDR = 7'h70;
    localparam logic [7:0]  BLD_RST_VAL    = 8'h00;
    localparam logic [3:0]  BLD_BYTE_BITS  = 4'h8;

    localparam logic [7:0]  BLD_ADR_SINK   = 8'h00;
    localparam logic [7:0]  BLD_ADR_BANK   = 8'h01;
    localparam logic [7:0]  BLD_ADR_CUR1   = 8'h02;
    localparam logic [7:0]  BLD_ADR_TGT1   = 8'h06;
    localparam logic [7:0]  BLD_ADR_LDO1   = 8'h0A;
    localparam logic [7:0]  BLD_ADR_LDO2   = 8'h0B;
    localparam logic [7:0]  BLD_ADR_LDO3   = 8'h0C;
    localparam logic [7:0]  BLD_ADR_LDO4   = 8'h0D;
    localparam logic [7:0]  BLD_ADR_ASSIGN = 8'h0E;
    localparam logic [7:0]  BLD_ADR_RATES  = 8'h0F;
    localparam logic [7:0]  BLD_ADR_TIME1  = 8'h10;
    localparam logic [7:0]  BLD_ADR_TIME2  = 8'h11;
    localparam logic [7:0]  BLD_ADR_ALS    = 8'h12;
    localparam logic [7:0]  BLD_ADR_RESULT = 8'h13;
    localparam logic [7:0]  BLD_ADR_RISE   = 8'h14;
    localparam logic [7:0]  BLD_ADR_FALL   = 8'h15;
    localparam logic [7:0]  BLD_ADR_DIM    = 8'h16;

    // bits software may store; the rest read back as zero or hardware state
    localparam logic [7:0]  BLD_WMASK [0:BLD_NUM_REGS-1] = '{
        8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h3F,
        8'h3F, 8'h3F, 8'h0F, 8'h07, 8'h0F, 8'h0F, 8'h1F, 8'h3F,
        8'h3F, 8'h3F, 8'h23, 8'h00, 8'hFF, 8'hFF, 8'h3F};

    localparam int          BLD_BANK_DIS   = 5;
    localparam int          BLD_BANK_EN    = 4;
    localparam int          BLD_FX_ON      = 5;
    localparam int          BLD_ALS_CMP    = 7;
    localparam int          BLD_ALS_INT    = 6;
    localparam int          BLD_ALS_SAT    = 5;
    localparam int          BLD_ALS_OF     = 4;
    localparam int          BLD_ALS_UF     = 3;
    localparam int          BLD_ALS_CLR    = 2;
    localparam int          BLD_ALS_AUTO   = 1;
    localparam int          BLD_ALS_EN     = 0;
    localparam int          BLD_DIM_ACT    = 6;
    localparam int          BLD_DIM_RATE   = 5;
    localparam int          BLD_DIM_ON     = 4;
    localparam int          BLD_DIM_BYP    = 0;

    typedef enum logic [8:0] {
        BLD_IDLE = 9'h001,
        BLD_ADDR = 9'h002,
        BLD_ACKA = 9'h004,
        BLD_REG  = 9'h008,
        BLD_ACKR = 9'h010,
        BLD_DATA = 9'h020,
        BLD_ACKD = 9'h040,
        BLD_READ = 9'h080,
        BLD_MACK = 9'h100
    } bld_state_e;
endpackage

/* rtl/bld_rf_if.sv */
interface bld_rf_if;
    import bld_pkg::*;
    logic             wr_en;
    logic [7:0]       addr;
    logic [7:0]       wr_data;
    logic [7:0]       rd_data;
    logic [7:0]       regs [0:BLD_NUM_REGS-1];

    modport master (output wr_en, output addr, output wr_data,
                    input rd_data, input regs);
    modport slave  (input wr_en, input addr, input wr_data,
                    output rd_data, output regs);
endinterface

/* rtl/bld_regfile.sv */
module bld_regfile
    import bld_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst_n,
    bld_rf_if.slave   rf
);
    logic [7:0] mem_r [0:BLD_NUM_REGS-1];
    logic [7:0] rd_data_r;
    wire        addr_ok = (rf.addr < 8'(BLD_NUM_REGS));

    genvar i;
    generate
        for (i = 0; i < BLD_NUM_REGS; i++) begin : g_word
            wire       hit = rf.wr_en && (rf.addr == 8'(i));
            // reserved bits never stored, so they read as zero
            wire [7:0] wr_val = rf.wr_data & BLD_WMASK[i];
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    mem_r[i] <= BLD_RST_VAL;
                end else if (hit) begin
                    mem_r[i] <= wr_val;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_r <= BLD_RST_VAL;
        end else begin
            rd_data_r <= addr_ok ? mem_r[rf.addr[4:0]] : 8'h00;
        end
    end

    assign rf.rd_data = rd_data_r;
    assign rf.regs    = mem_r;
endmodule

/* dv/bld_top_monitor.sv */
module bld_top_monitor (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        scl_in,
    input wire logic        sda_in,
    input wire logic        sda_out,
    input wire logic        sda_oe,
    input wire logic        light_irq_event,
    input wire logic        light_irq_n,
    input wire logic [7:0]  sink_on,
    input wire logic [19:0] start_level,
    input wire logic [19:0] goal_level,
    input wire logic [14:0] regulator_code,
    input wire logic [11:0] set_timing
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    sequence bus_stop;
        scl_in && $past(scl_in) && $rose(sda_in);
    endsequence
    // a change while scl is high would look like a start or stop on the wire
    sequence scl_low_two;
        !scl_in && !$past(scl_in);
    endsequence
    AST_SDA_OUT_LOW: assert property (sda_out == 1'b0)
        else $error("sda_out not low");
    AST_RESET_ZERO: assert property ($rose(rst_n) |-> sink_on == 8'h00
        && regulator_code == 15'h0000 && light_irq_n && !sda_oe)
        else $error("outputs not at reset value");
    AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> scl_low_two)
        else $error("sda_oe moved while scl high");
    AST_STOP_RELEASE: assert property (bus_stop |=> !sda_oe [*4])
        else $error("sda driven after stop");
    AST_IRQ_SET: assert property (light_irq_event |-> ##[1:3] !light_irq_n)
        else $error("irq not raised");
    AST_IRQ_CAUSE: assert property ($fell(light_irq_n) |-> $past(light_irq_event)
        || $past(light_irq_event, 2) || $past(light_irq_event, 3))
        else $error("irq raised without event");
    AST_SINK_MOVE: assert property ($changed(sink_on) |-> scl_low_two)
        else $error("sink_on moved off a write");
    AST_LEVEL_MOVE: assert property ($changed(start_level) |-> scl_low_two)
        else $error("start_level moved off a write");
    AST_GOAL_MOVE: assert property ($changed(goal_level) |-> scl_low_two)
        else $error("goal_level moved off a write");
    AST_LDO_MOVE: assert property ($changed(regulator_code) |-> scl_low_two)
        else $error("regulator_code moved off a write");
    AST_TIME_MOVE: assert property ($changed(set_timing) |-> scl_low_two)
        else $error("set_timing moved off a write");
endmodule

bind bld_top bld_top_monitor mon (.core_clk, .rst_n, .scl_in, .sda_in, .sda_out, .sda_oe,
    .light_irq_event, .light_irq_n, .sink_on, .start_level, .goal_level, .regulator_code,
    .set_timing);

/* dv/bld_host.sv */
module bld_host (
    input  wire logic core_clk,
    input  wire logic sda_in,
    output logic      scl = 1'b1,
    output logic      sda_low = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] acks = 8'h00;
    // six cycles a phase, above the four that the slave needs
    task automatic half();
        repeat (6) @(negedge core_clk);
    endtask
    task automatic start();
        sda_low = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b1;
        half();
        scl = 1'b0;
    endtask
    task automatic stop();
        sda_low = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b0;
        half();
    endtask
    task automatic clk_bit();
        half();
        scl = 1'b1;
        half();
    endtask
    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sda_low = !b[i];
            clk_bit();
            scl = 1'b0;
        end
        sda_low = 1'b0;
        clk_bit();
        acks = {acks[6:0], !sda_in};
        scl = 1'b0;
    endtask
    // sda stays released through the ninth bit, which is the nack
    task automatic recv(output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            clk_bit();
            b[i] = sda_in;
            scl = 1'b0;
        end
        clk_bit();
        scl = 1'b0;
    endtask
    task automatic other(input logic [7:0] a);
        start();
        send(a);
        stop();
    endtask
    task automatic ptr(input logic [7:0] a);
        start();
        send(8'hE0);
        send(a);
        stop();
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        start();
        send(8'hE0);
        send(a);
        send(d);
        stop();
    endtask
    task automatic rd(output logic [7:0] d);
        start();
        send(8'hE1);
        recv(d);
        stop();
    endtask
    task automatic rdc(input logic [7:0] a, output logic [7:0] d);
        start();
        send(8'hE0);
        send(a);
        rd(d);
    endtask
endmodule

/* dv/bld_top_bench.sv */
module bld_top_bench
    import bld_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        scl_in;
    logic        host_low;
    wire logic   sda_in;
    logic        sda_out, sda_oe, light_irq_n, light_adc_on, light_auto_on, light_saturate_on;
    logic        dropout_guard_on, dropout_guard_rate, pulse_input_bypass;
    logic [7:0]  adc_result = 8'h00;
    logic        light_compare_result = 1'b0, light_overflow = 1'b0, light_underflow = 1'b0;
    logic        light_irq_event = 1'b0, dropout_guard_active = 1'b0;
    logic [7:0]  sink_on, light_rise_level, light_fall_level, d;
    logic [3:0]  bank_on, first_group_fade_on, first_group_pulse_on;
    logic [19:0] start_level, goal_level;
    logic [14:0] regulator_code;
    logic [1:0]  effect_set_select;
    logic [2:0]  effect_zone_select, auto_dim_select;
    logic [5:0]  set_rate;
    logic [11:0] set_timing;
    int          fails = 0;
    int          tests_run = 0;
    localparam logic [7:0]  KEEP [0:22] = '{8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h3F,
        8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h0F, 8'h07, 8'h0F, 8'h0F, 8'h1F, 8'h3F, 8'h3F,
        8'h3F, 8'h23, 8'h00, 8'hFF, 8'hFF, 8'h3F};
    localparam logic [15:0] PAT [0:10] = '{16'h0215, 16'h060A, 16'h0A03, 16'h0B05,
        16'h0E0B, 16'h0F2C, 16'h100C, 16'h1121, 16'h14A5, 16'h155A, 16'h161A};
    localparam logic [19:0] BANKT [0:4] = '{20'h030FF, 20'h1553F, 20'h2413F, 20'h1233F,
        20'h3033F};

    always #4 core_clk = ~core_clk;
    // open drain with pull-up: high unless someone pulls
    assign sda_in = !(host_low || sda_oe);

    bld_top dut (.core_clk, .rst_n, .scl_in, .sda_in, .sda_out, .sda_oe, .adc_result,
        .light_compare_result, .light_overflow, .light_underflow, .light_irq_event,
        .dropout_guard_active, .sink_on, .bank_on, .first_group_fade_on, .start_level,
        .first_group_pulse_on, .goal_level, .regulator_code, .effect_set_select,
        .effect_zone_select, .set_rate, .set_timing, .light_adc_on, .light_auto_on,
        .light_saturate_on, .light_irq_n, .light_rise_level, .light_fall_level,
        .dropout_guard_on, .dropout_guard_rate, .auto_dim_select, .pulse_input_bypass);
    bld_host host (.core_clk, .sda_in, .scl(scl_in), .sda_low(host_low));

    task automatic check_reg(input string what, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic check_port(input string what, input logic [19:0] e, input logic [19:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
        host.rdc(a, d);
        check_reg($sformatf("register %h", a), e, d);
    endtask
    task automatic check_outs(input logic [19:0] e [0:8]);
        logic [19:0] got [0:8];
        got = '{{12'h0, sink_on}, start_level, goal_level,
            {12'h0, first_group_fade_on, first_group_pulse_on}, {5'h0, regulator_code},
            {9'h0, effect_set_select, effect_zone_select, set_rate}, {8'h0, set_timing},
            {4'h0, light_rise_level, light_fall_level}, {10'h0, light_adc_on, light_auto_on,
            light_saturate_on, dropout_guard_on, dropout_guard_rate, auto_dim_select,
            pulse_input_bypass, light_irq_n}};
        for (int i = 0; i < 9; i++) begin
            check_port($sformatf("output group %0d", i), e[i], got[i]);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // the full sequence needs about 42000 cycles
    initial begin
        repeat (80000) @(posedge core_clk);
        fails++;
        conclude();
    end

    initial begin
        repeat (12) @(posedge core_clk);
        @(negedge core_clk) rst_n = 1'b1;
        repeat (2) @(negedge core_clk);
        for (int i = 0; i <= BLD_NUM_REGS; i++) begin
            expect_reg(i[7:0], 8'h00);
        end
        check_port("read acks", 20'h7, {17'h0, host.acks[2:0]});
        $display("test reset values done");
        for (int i = 0; i < BLD_NUM_REGS; i++) begin
            host.wr(i[7:0], 8'hFF);
            check_port("write acks", 20'h7, {17'h0, host.acks[2:0]});
            host.ptr(i[7:0]);
            host.rd(d);
            check_reg("stored bits", KEEP[i], d);
        end
        check_outs('{20'h3F, 20'hFFFFF, 20'hFFFFF, 20'hFF, 20'h7FFF, 20'h7FF, 20'hFFF, 20'hFFFF,
            20'h3FF});
        $display("test reserved bits done");
        for (int i = 0; i < 11; i++) begin
            host.wr(PAT[i][15:8], PAT[i][7:0]);
        end
        check_outs('{20'h3F, 20'hFFFF5, 20'hFFFEA, 20'hEE, 20'h7FD3, 20'h2EC, 20'h84C, 20'hA55A,
            20'h3D5});
        $display("test field placement done");
        for (int i = 0; i < 5; i++) begin
            host.wr(8'h01, BANKT[i][19:12]);
            check_port("bank and sink", {8'h0, BANKT[i][11:0]}, {8'h0, bank_on, sink_on});
        end
        $display("test bank control done");
        adc_result = 8'h5A;
        light_compare_result = 1'b1;
        light_underflow = 1'b1;
        dropout_guard_active = 1'b1;
        light_irq_event = 1'b1;
        @(negedge core_clk) light_irq_event = 1'b0;
        repeat (4) @(negedge core_clk);
        check_port("irq_n set", 20'h0, {19'h0, light_irq_n});
        expect_reg(8'h12, 8'hEB);
        expect_reg(8'h16, 8'h5A);
        host.wr(8'h13, 8'h00);
        expect_reg(8'h13, 8'h5A);
        host.wr(8'h12, 8'h27);
        check_port("irq_n cleared", 20'h1, {19'h0, light_irq_n});
        expect_reg(8'h12, 8'hAB);
        // swap the range flags so each bit position is seen set and clear
        light_overflow = 1'b1;
        light_underflow = 1'b0;
        expect_reg(8'h12, 8'hB3);
        $display("test status done");
        host.ptr(8'h14);
        host.other(8'hE2);
        host.other(8'hF0);
        check_port("foreign acks", 20'h0, {18'h0, host.acks[1:0]});
        host.rd(d);
        check_reg("kept pointer", 8'hA5, d);
        host.wr(8'h17, 8'h55);
        check_port("unmapped acks", 20'h7, {17'h0, host.acks[2:0]});
        expect_reg(8'h17, 8'h00);
        $display("test addressing done");
        conclude();
    end
endmodule
